// [verilog/pga_pkg.sv]
`default_nettype none
package pga_pkg;
  localparam int AD_W     = 32;
  localparam int NUM_REQ  = 3;
  localparam int LEN_W    = 8;
  localparam int MEM_AW   = 4;
  localparam int ADDR_LSB = 2;
  localparam int IDX_ONE   = 0;
  localparam int IDX_TWO   = 1;
  localparam int IDX_THREE = 2;
  // Legal rate of the bus clock in MHz, kept for reference only
  localparam int PCI_CLK_MIN_MHZ = 20;
  localparam int PCI_CLK_MAX_MHZ = 33;

  localparam logic [NUM_REQ-1:0] GNT_NONE = 3'h0;
  // Last owner preset to index three so the first pick starts at one
  localparam logic [NUM_REQ-1:0] RR_RESET = 3'h4;
  localparam logic [LEN_W-1:0]   BEAT_ONE = 8'h01;
  localparam logic [LEN_W-1:0]   BEAT_TWO = 8'h02;
  localparam logic [AD_W-1:0]    AD_ZERO  = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT = 3'b001,
    ST_ADDR = 3'b010,
    ST_TURN = 3'b011,
    ST_DATA = 3'b100
  } pga_state_e;
endpackage
`default_nettype wire

// [verilog/pga_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface pga_if;
  logic                     arb_request_in_one_n;
  logic                     arb_request_in_two_n;
  logic                     arb_request_in_three_n;
  logic                     arb_grant_out_one_n;
  logic                     arb_grant_out_two_n;
  logic                     arb_grant_out_three_n;
  logic [pga_pkg::AD_W-1:0] dev_ad;
  logic                     dev_ad_oe;
  logic [pga_pkg::AD_W-1:0] tgt_ad;
  logic                     tgt_ad_oe;
  logic [pga_pkg::AD_W-1:0] ad;
  logic                     xfer_cyc;
  logic                     xfer_addr;
  logic                     xfer_last;
  logic                     xfer_write;

  // Shared lines resolved from the enables; an idle bus reads zero
  assign ad = dev_ad_oe ? dev_ad : (tgt_ad_oe ? tgt_ad : pga_pkg::AD_ZERO);

  modport dev (
    input  arb_request_in_one_n, arb_request_in_two_n, arb_request_in_three_n, ad,
    output arb_grant_out_one_n, arb_grant_out_two_n, arb_grant_out_three_n,
    output dev_ad, dev_ad_oe, xfer_cyc, xfer_addr, xfer_last, xfer_write
  );
  modport far (
    output arb_request_in_one_n, arb_request_in_two_n, arb_request_in_three_n,
    output tgt_ad, tgt_ad_oe,
    input  arb_grant_out_one_n, arb_grant_out_two_n, arb_grant_out_three_n, ad,
    input  xfer_cyc, xfer_addr, xfer_last, xfer_write
  );
endinterface
`default_nettype wire

// [verilog/pga_device.sv]
`timescale 1ns/1ps
`default_nettype none
module pga_device #(
  parameter int LEN_W = pga_pkg::LEN_W
) (
  input  wire logic                     ref_clk_i,
  input  wire logic                     sys_rst_i,
  input  wire logic                     host_mode_i,
  input  wire logic                     start_i,
  input  wire logic                     write_i,
  input  wire logic [pga_pkg::AD_W-1:0] addr_i,
  input  wire logic [LEN_W-1:0]         beats_i,
  input  wire logic [pga_pkg::AD_W-1:0] wdata_i,
  output logic                          wdata_take_o,
  output logic [pga_pkg::AD_W-1:0]      rdata_o,
  output logic                          rdata_valid_o,
  output logic                          busy_o,
  output logic                          done_o,
  output logic [pga_pkg::NUM_REQ-1:0]   grant_vec_o,
  pga_if.dev                            bus
);

  ////////////////////////////////////////////////////////////////////////////////
  // Round-robin pick, starting after the last owner
  function automatic logic [pga_pkg::NUM_REQ-1:0] rr_pick(
    input logic [pga_pkg::NUM_REQ-1:0] req,
    input logic [pga_pkg::NUM_REQ-1:0] last
  );
    logic [pga_pkg::NUM_REQ-1:0] pick;
    int                          base;
    int                          idx;
    pick = pga_pkg::GNT_NONE;
    base = last[pga_pkg::IDX_ONE] ? pga_pkg::IDX_TWO :
           (last[pga_pkg::IDX_TWO] ? pga_pkg::IDX_THREE : pga_pkg::IDX_ONE);
    for (int k = 0; k < pga_pkg::NUM_REQ; k++) begin
      idx = (base + k) % pga_pkg::NUM_REQ;
      if (pick == pga_pkg::GNT_NONE && req[idx]) begin
        pick[idx] = 1'b1;
      end
    end
    return pick;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State
  pga_pkg::pga_state_e          state_q, state_d;
  logic [pga_pkg::AD_W-1:0]     addr_q, addr_d;
  logic [pga_pkg::AD_W-1:0]     ad_q, ad_d;
  logic                         oe_q, oe_d;
  logic                         cyc_q, cyc_d;
  logic                         adr_q, adr_d;
  logic                         last_q, last_d;
  logic                         wr_q, wr_d;
  logic [LEN_W-1:0]             rem_q, rem_d;
  logic                         own_req_q, own_req_d;
  logic [pga_pkg::AD_W-1:0]     rdata_q, rdata_d;
  logic                         rvalid_q, rvalid_d;
  logic                         done_q, done_d;
  logic [pga_pkg::NUM_REQ-1:0]  gnt_q, gnt_d;
  logic [pga_pkg::NUM_REQ-1:0]  last_gnt_q, last_gnt_d;
  logic [pga_pkg::NUM_REQ-1:0]  reqs;
  logic                         bus_ok;

  assign reqs = ~{bus.arb_request_in_three_n,
                  bus.arb_request_in_two_n,
                  bus.arb_request_in_one_n};

  // Host mode: own master only while no external owner is granted
  // Guest mode: external arbiter answers on request input one
  assign bus_ok = host_mode_i ? (gnt_q == pga_pkg::GNT_NONE)
                              : !bus.arb_request_in_one_n;

  ////////////////////////////////////////////////////////////////////////////////
  // Master sequencer
  always_comb begin
    state_d   = state_q;
    addr_d    = addr_q;
    ad_d      = ad_q;
    oe_d      = oe_q;
    cyc_d     = cyc_q;
    adr_d     = adr_q;
    last_d    = last_q;
    wr_d      = wr_q;
    rem_d     = rem_q;
    own_req_d = own_req_q;
    rdata_d   = rdata_q;
    rvalid_d  = 1'b0;
    done_d    = 1'b0;
    case (state_q)
      pga_pkg::ST_IDLE: begin
        if (start_i) begin
          addr_d    = addr_i;
          wr_d      = write_i;
          // A zero length is taken as a single beat
          rem_d     = (beats_i == '0) ? pga_pkg::BEAT_ONE : beats_i;
          own_req_d = !host_mode_i;
          state_d   = pga_pkg::ST_WAIT;
        end
      end
      pga_pkg::ST_WAIT: begin
        if (bus_ok) begin
          ad_d      = addr_q;
          oe_d      = 1'b1;
          cyc_d     = 1'b1;
          adr_d     = 1'b1;
          // Request is dropped once the bus is won
          own_req_d = 1'b0;
          state_d   = pga_pkg::ST_ADDR;
        end
      end
      pga_pkg::ST_ADDR: begin
        adr_d = 1'b0;
        if (wr_q) begin
          ad_d    = wdata_i;
          last_d  = (rem_q == pga_pkg::BEAT_ONE);
          state_d = pga_pkg::ST_DATA;
        end else begin
          // Release the lines for one idle cycle before the target drives
          oe_d    = 1'b0;
          state_d = pga_pkg::ST_TURN;
        end
      end
      pga_pkg::ST_TURN: begin
        last_d  = (rem_q == pga_pkg::BEAT_ONE);
        state_d = pga_pkg::ST_DATA;
      end
      pga_pkg::ST_DATA: begin
        rem_d = rem_q - pga_pkg::BEAT_ONE;
        if (!wr_q) begin
          rdata_d  = bus.ad;
          rvalid_d = 1'b1;
        end
        if (last_q) begin
          oe_d    = 1'b0;
          cyc_d   = 1'b0;
          last_d  = 1'b0;
          done_d  = 1'b1;
          state_d = pga_pkg::ST_IDLE;
        end else begin
          last_d = (rem_q == pga_pkg::BEAT_TWO);
          if (wr_q) begin
            ad_d = wdata_i;
          end
        end
      end
      default: begin
        state_d = pga_pkg::ST_IDLE;
        oe_d    = 1'b0;
        cyc_d   = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Host arbiter
  always_comb begin
    gnt_d      = gnt_q;
    last_gnt_d = last_gnt_q;
    if (!host_mode_i) begin
      gnt_d = pga_pkg::GNT_NONE;
    end else if (gnt_q != pga_pkg::GNT_NONE) begin
      // Owner keeps the bus until it lets its request go
      if ((gnt_q & reqs) == pga_pkg::GNT_NONE) begin
        gnt_d = pga_pkg::GNT_NONE;
      end
    end else if (state_q == pga_pkg::ST_IDLE && !start_i && reqs != pga_pkg::GNT_NONE) begin
      // A free cycle always separates two owners, so drivers never overlap
      gnt_d      = rr_pick(reqs, last_gnt_q);
      last_gnt_d = gnt_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_q    <= pga_pkg::ST_IDLE;
      addr_q     <= pga_pkg::AD_ZERO;
      ad_q       <= pga_pkg::AD_ZERO;
      oe_q       <= 1'b0;
      cyc_q      <= 1'b0;
      adr_q      <= 1'b0;
      last_q     <= 1'b0;
      wr_q       <= 1'b0;
      rem_q      <= '0;
      own_req_q  <= 1'b0;
      rdata_q    <= pga_pkg::AD_ZERO;
      rvalid_q   <= 1'b0;
      done_q     <= 1'b0;
      gnt_q      <= pga_pkg::GNT_NONE;
      last_gnt_q <= pga_pkg::RR_RESET;
    end else begin
      state_q    <= state_d;
      addr_q     <= addr_d;
      ad_q       <= ad_d;
      oe_q       <= oe_d;
      cyc_q      <= cyc_d;
      adr_q      <= adr_d;
      last_q     <= last_d;
      wr_q       <= wr_d;
      rem_q      <= rem_d;
      own_req_q  <= own_req_d;
      rdata_q    <= rdata_d;
      rvalid_q   <= rvalid_d;
      done_q     <= done_d;
      gnt_q      <= gnt_d;
      last_gnt_q <= last_gnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pins and user side
  assign bus.arb_grant_out_one_n   = host_mode_i ? ~gnt_q[pga_pkg::IDX_ONE]
                                                 : ~own_req_q;
  // Reserved pins held inactive high in guest mode
  assign bus.arb_grant_out_two_n   = host_mode_i ? ~gnt_q[pga_pkg::IDX_TWO] : 1'b1;
  assign bus.arb_grant_out_three_n = host_mode_i ? ~gnt_q[pga_pkg::IDX_THREE] : 1'b1;
  assign bus.dev_ad                = ad_q;
  assign bus.dev_ad_oe             = oe_q;
  assign bus.xfer_cyc              = cyc_q;
  assign bus.xfer_addr             = adr_q;
  assign bus.xfer_last             = last_q;
  assign bus.xfer_write            = wr_q;

  assign wdata_take_o  = wr_q && ((state_q == pga_pkg::ST_ADDR) ||
                                  (state_q == pga_pkg::ST_DATA && !last_q));
  assign rdata_o       = rdata_q;
  assign rdata_valid_o = rvalid_q;
  assign busy_o        = (state_q != pga_pkg::ST_IDLE);
  assign done_o        = done_q;
  assign grant_vec_o   = gnt_q;

endmodule
`default_nettype wire

// [verilog/pga_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module pga_partner #(
  parameter int MEM_AW = pga_pkg::MEM_AW
) (
  input  wire logic                       ref_clk_i,
  input  wire logic                       sys_rst_i,
  input  wire logic                       host_mode_i,
  input  wire logic [pga_pkg::NUM_REQ-1:0] ext_req_i,
  output logic [pga_pkg::NUM_REQ-1:0]      ext_gnt_o,
  input  wire logic                       grant_en_i,
  output logic                            wr_strobe_o,
  output logic [pga_pkg::AD_W-1:0]        wr_data_o,
  pga_if.far                              bus
);

  logic [pga_pkg::AD_W-1:0] mem [2**MEM_AW];
  logic [MEM_AW-1:0]        idx_q, idx_d;
  logic                     rd_q, rd_d;
  logic                     oe_q, oe_d;
  logic [pga_pkg::AD_W-1:0] ad_q, ad_d;
  logic                     park_q, park_d;
  logic                     wstb_q, wstb_d;
  logic [pga_pkg::AD_W-1:0] wdat_q, wdat_d;
  logic                     data_ph;

  assign data_ph = bus.xfer_cyc && !bus.xfer_addr;

  ////////////////////////////////////////////////////////////////////////////////
  // Arbiter toward the device in guest mode, masters in host mode
  assign park_d = !host_mode_i && grant_en_i && !bus.arb_grant_out_one_n;
  assign bus.arb_request_in_one_n   = host_mode_i ? !ext_req_i[pga_pkg::IDX_ONE] : !park_q;
  assign bus.arb_request_in_two_n   = host_mode_i ? !ext_req_i[pga_pkg::IDX_TWO] : 1'b1;
  assign bus.arb_request_in_three_n = host_mode_i ? !ext_req_i[pga_pkg::IDX_THREE] : 1'b1;
  assign ext_gnt_o = host_mode_i ? ~{bus.arb_grant_out_three_n, bus.arb_grant_out_two_n,
                                     bus.arb_grant_out_one_n} : pga_pkg::GNT_NONE;

  ////////////////////////////////////////////////////////////////////////////////
  // Target: word memory, one beat per data phase, no wait states
  always_comb begin
    idx_d  = idx_q;
    rd_d   = rd_q;
    oe_d   = oe_q;
    ad_d   = ad_q;
    wstb_d = 1'b0;
    wdat_d = wdat_q;
    if (bus.xfer_cyc && bus.xfer_addr) begin
      idx_d = bus.ad[pga_pkg::ADDR_LSB +: MEM_AW];
      rd_d  = !bus.xfer_write;
      oe_d  = 1'b0;
    end else if (data_ph && bus.xfer_write) begin
      wstb_d = 1'b1;
      wdat_d = bus.ad;
      idx_d  = idx_q + MEM_AW'(1);
    end else if (rd_q) begin
      // Lines stay released in the turnaround; the first word comes after it
      if (bus.xfer_last && oe_q) begin
        oe_d = 1'b0;
        rd_d = 1'b0;
      end else begin
        oe_d  = 1'b1;
        ad_d  = mem[idx_q];
        idx_d = idx_q + MEM_AW'(1);
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (wstb_d) begin
      mem[idx_q] <= bus.ad;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      idx_q  <= '0;
      rd_q   <= 1'b0;
      oe_q   <= 1'b0;
      ad_q   <= pga_pkg::AD_ZERO;
      park_q <= 1'b0;
      wstb_q <= 1'b0;
      wdat_q <= pga_pkg::AD_ZERO;
    end else begin
      idx_q  <= idx_d;
      rd_q   <= rd_d;
      oe_q   <= oe_d;
      ad_q   <= ad_d;
      park_q <= park_d;
      wstb_q <= wstb_d;
      wdat_q <= wdat_d;
    end
  end

  assign bus.tgt_ad    = ad_q;
  assign bus.tgt_ad_oe = oe_q;
  assign wr_strobe_o   = wstb_q;
  assign wr_data_o     = wdat_q;

endmodule
`default_nettype wire

// [verif/pga_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module pga_checker (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic host_mode_i,
  input wire logic arb_request_in_one_n,
  input wire logic arb_request_in_two_n,
  input wire logic arb_request_in_three_n,
  input wire logic arb_grant_out_one_n,
  input wire logic arb_grant_out_two_n,
  input wire logic arb_grant_out_three_n,
  input wire logic dev_ad_oe,
  input wire logic tgt_ad_oe,
  input wire logic xfer_cyc,
  input wire logic xfer_addr,
  input wire logic xfer_last,
  input wire logic xfer_write
);
  logic [2:0] g;
  logic [2:0] r;
  // Active-high views of the pins, bit 0 is index one
  assign g = ~{arb_grant_out_three_n, arb_grant_out_two_n, arb_grant_out_one_n};
  assign r = ~{arb_request_in_three_n, arb_request_in_two_n, arb_request_in_one_n};
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  ////////////////////////////////////////////////////////////
  // Grant is registered, so it answers the request of the cycle before
  grant_match_a: assert property (host_mode_i |-> (g & $past(r)) == g)
    else $error("grant without matching request");
  one_grant_a: assert property (host_mode_i |-> $onehot0(g))
    else $error("more than one grant");
  owner_gap_a: assert property (g != 3'h0 && $past(g) != 3'h0 |-> g == $past(g))
    else $error("grant moved with no idle cycle");
  guest_reserved_a: assert property (!host_mode_i |-> g[2:1] == 2'h0)
    else $error("reserved grant driven in guest mode");
  guest_grant_a: assert property (!host_mode_i && $rose(xfer_cyc) |-> $past(g[0] && r[0]))
    else $error("guest cycle began without request and grant");
  host_owner_a: assert property (host_mode_i && xfer_cyc |-> g == 3'h0)
    else $error("device owns bus while a grant is out");
  addr_phase_a: assert property (xfer_addr |-> xfer_cyc && dev_ad_oe ##1 xfer_cyc && !xfer_addr)
    else $error("address phase malformed");
  read_turn_a: assert property (xfer_addr && !xfer_write |=> !dev_ad_oe && !tgt_ad_oe ##1 tgt_ad_oe)
    else $error("read turnaround missing");
  write_drive_a: assert property (xfer_cyc && xfer_write |-> dev_ad_oe && !tgt_ad_oe)
    else $error("write data not driven by device");
  read_drive_a: assert property (xfer_last && !xfer_write |-> tgt_ad_oe && !dev_ad_oe)
    else $error("read data not driven by target");
  frame_end_a: assert property (xfer_last |=> !xfer_cyc && !dev_ad_oe && !tgt_ad_oe)
    else $error("bus not released after last beat");
endmodule
`default_nettype wire

// [verif/pci_request_grant_arbiter_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module pci_request_grant_arbiter_tb_top;
  localparam logic [pga_pkg::AD_W-1:0] STEP = 32'h0001_0003;
  logic                     ref_clk_i   = 1'b0;
  logic                     sys_rst_i   = 1'b1;
  logic                     host_mode_i = 1'b1;
  logic                     start_i     = 1'b0;
  logic                     write_i     = 1'b0;
  logic                     grant_en_i  = 1'b0;
  logic [2:0]               ext_req_i   = 3'h0;
  logic [7:0]               beats_i     = 8'h00;
  logic [pga_pkg::AD_W-1:0] addr_i      = 32'h0000_0000;
  logic [pga_pkg::AD_W-1:0] wdata_i     = 32'h1234_0000;
  logic [pga_pkg::AD_W-1:0] rdata_o, wr_data_o, seen_addr;
  logic [pga_pkg::AD_W-1:0] mdl [16];
  logic [pga_pkg::AD_W-1:0] wq [$];
  logic [pga_pkg::AD_W-1:0] rq [$];
  logic                     wdata_take_o, rdata_valid_o, busy_o, done_o, wr_strobe_o;
  logic [2:0]               grant_vec_o, ext_gnt_o;
  int                       n_errors    = 0;
  int                       comparisons = 0;

  always #12.5 ref_clk_i = ~ref_clk_i;

  pga_if u_pga_if ();
  pga_device u_pga_device (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .host_mode_i(host_mode_i), .start_i(start_i), .write_i(write_i), .addr_i(addr_i),
    .beats_i(beats_i), .wdata_i(wdata_i), .wdata_take_o(wdata_take_o), .rdata_o(rdata_o),
    .rdata_valid_o(rdata_valid_o), .busy_o(busy_o), .done_o(done_o),
    .grant_vec_o(grant_vec_o), .bus(u_pga_if));
  pga_partner u_pga_partner (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .host_mode_i(host_mode_i), .ext_req_i(ext_req_i), .ext_gnt_o(ext_gnt_o),
    .grant_en_i(grant_en_i), .wr_strobe_o(wr_strobe_o), .wr_data_o(wr_data_o),
    .bus(u_pga_if));
  pga_checker u_pga_checker (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .host_mode_i(host_mode_i), .arb_request_in_one_n(u_pga_if.arb_request_in_one_n),
    .arb_request_in_two_n(u_pga_if.arb_request_in_two_n),
    .arb_request_in_three_n(u_pga_if.arb_request_in_three_n),
    .arb_grant_out_one_n(u_pga_if.arb_grant_out_one_n),
    .arb_grant_out_two_n(u_pga_if.arb_grant_out_two_n),
    .arb_grant_out_three_n(u_pga_if.arb_grant_out_three_n),
    .dev_ad_oe(u_pga_if.dev_ad_oe), .tgt_ad_oe(u_pga_if.tgt_ad_oe),
    .xfer_cyc(u_pga_if.xfer_cyc), .xfer_addr(u_pga_if.xfer_addr),
    .xfer_last(u_pga_if.xfer_last), .xfer_write(u_pga_if.xfer_write));

  ////////////////////////////////////////////////////////////
  // Write words step on each take, so a skipped or doubled beat shows up
  always @(posedge ref_clk_i) begin
    if (wdata_take_o === 1'b1) wdata_i <= wdata_i + STEP;
    if (wr_strobe_o === 1'b1) wq.push_back(wr_data_o);
    if (rdata_valid_o === 1'b1) rq.push_back(rdata_o);
    if (u_pga_if.xfer_addr === 1'b1) seen_addr <= u_pga_if.ad;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic xfer(input logic wr, input logic [31:0] a, input logic [7:0] n);
    int                       k;
    int                       t;
    logic [pga_pkg::AD_W-1:0] w;
    k = (n == 8'h00) ? 1 : int'(n);
    w = wdata_i;
    t = 0;
    wq.delete();
    rq.delete();
    write_i <= wr;
    addr_i  <= a;
    beats_i <= n;
    start_i <= 1'b1;
    @(posedge ref_clk_i);
    start_i <= 1'b0;
    @(posedge ref_clk_i);
    chk("busy", 1, 32'(busy_o));
    while (done_o !== 1'b1 && t < 200) begin
      @(posedge ref_clk_i);
      t++;
    end
    @(posedge ref_clk_i);
    chk("done", 1, 32'(t < 200));
    chk("idle", 0, 32'(busy_o));
    chk("address phase", a, seen_addr);
    chk("beats", 32'(k), 32'(wr ? wq.size() : rq.size()));
    for (int i = 0; i < k; i++) begin
      if (wr) mdl[4'(a[5:2] + i)] = w + 32'(i) * STEP;
      chk("beat word", mdl[4'(a[5:2] + i)], wr ? wq[i] : rq[i]);
    end
  endtask

  // Waits out the old owner first, so its grant is not taken for the new one
  task automatic arb_step(input logic [2:0] req, input logic [2:0] exp);
    int t;
    t = 0;
    ext_req_i <= req;
    do begin @(posedge ref_clk_i); t++; end while (ext_gnt_o !== 3'h0 && t < 20);
    do begin @(posedge ref_clk_i); t++; end while (ext_gnt_o === 3'h0 && t < 40);
    chk("grant pins", 32'(exp), 32'(ext_gnt_o));
    chk("grant vector", 32'(exp), 32'(grant_vec_o));
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge ref_clk_i);
    xfer(1'b1, 32'h0000_0010, 8'h04);
    xfer(1'b0, 32'h0000_0010, 8'h04);
    xfer(1'b1, 32'h0000_003c, 8'h00);
    xfer(1'b0, 32'h0000_003c, 8'h01);
    $display("test host bursts finished");
    arb_step(3'h7, 3'h1);
    arb_step(3'h6, 3'h2);
    // Owner two with one and three waiting: rotation picks three, fixed order would pick one
    arb_step(3'h5, 3'h4);
    arb_step(3'h3, 3'h1);
    ext_req_i <= 3'h1;
    // Device must stay off the bus until the external owner lets go
    fork
      xfer(1'b1, 32'h0000_0020, 8'h02);
      begin
        repeat (8) @(posedge ref_clk_i);
        ext_req_i <= 3'h0;
      end
    join
    $display("test host arbitration finished");
    host_mode_i <= 1'b0;
    ext_req_i   <= 3'h7;
    fork
      xfer(1'b1, 32'h0000_0030, 8'h02);
      begin
        repeat (10) @(posedge ref_clk_i);
        chk("own request", 0, 32'(u_pga_if.arb_grant_out_one_n));
        chk("reserved grants", 3, 32'({u_pga_if.arb_grant_out_three_n,
          u_pga_if.arb_grant_out_two_n}));
        chk("guest pin grants", 0, 32'(ext_gnt_o));
        grant_en_i <= 1'b1;
      end
    join
    xfer(1'b0, 32'h0000_0030, 8'h02);
    $display("test guest mode finished");
    give_verdict();
  end

  initial begin
    repeat (5000) @(posedge ref_clk_i);
    n_errors++;
    $display("CHECK FAILED watchdog expected finish seen hang");
    give_verdict();
  end
endmodule
`default_nettype wire
